//--- scspi_top.sv
// Speed command select, analog scaling and command pulse inhibit.
// Assumes one 125 MHz clock, synchronous inputs, plain register port.
// Operation
// - While inhibit is enabled and active, command pulses do not change the pulse counter.
// - Inhibit is disabled after reset and a one-bit setting enables it.
// - The inhibit state follows the input only after agreeing samples in a 0..4 period.
// - The analog voltage is scaled by a gain of 10 to 2000 rpm per volt.
// - A signed offset of -5578..5578 steps is added to the analog sample.
// - The analog sample passes a first-order lag with time constant 0..6400 units.
// - A polarity bit inverts the sign of the analog command.
// - A direction bit selects how the command sign is determined.
// - Three select inputs pick one of eight stored speeds.
// - Source defaults to analog; settings 1..3 enable the internal speeds.
// - Each stored speed is held between -20000 and 20000 rpm.
// - An enabled active zero clamp forces the speed command to zero.
// - A 0..3 setting decides how the zero clamp acts.
// - With setting 2 or 3 a level decides when position holding takes over.
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "scspi_consts.svh"
module scspi_top
  import scspi_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic [4:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic CMD_PULSE,
  input wire logic CMD_DIR,
  input wire logic PULSE_INHIBIT_IN,
  input wire logic SPEED_SELECT_BIT0,
  input wire logic SPEED_SELECT_BIT1,
  input wire logic SPEED_SELECT_BIT2,
  input wire logic ZERO_CLAMP_IN,
  input wire logic DIR_SIGN_IN,
  input wire logic signed [15:0] ANALOG_INPUT_ONE,
  output logic signed [31:0] SPEED_CMD,
  output logic [31:0] PULSE_COUNT,
  output logic POSITION_HOLD
);
  import scspi_pkg::*;

  typedef struct packed {
    scspi_cfg_t cfg;
    scspi_cfg_t act;
    logic [31:0] pcount;
    logic [11:0] tick;
    logic signed [31:0] filt;
    logic signed [31:0] speed;
    logic hold;
    logic [31:0] rdata;
  } scspi_state_t;

  scspi_state_t s_r, s_nxt;
  scspi_bus_t bus;
  logic inh_state;
  logic [2:0] sel_idx;
  logic signed [31:0] table_rd;
  logic tbl_we;

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic logic signed [31:0] sat_speed(input logic signed [31:0] v);
    if (v > `SCSPI_SPD_MAX) begin
      sat_speed = `SCSPI_SPD_MAX;
    end else if (v < -`SCSPI_SPD_MAX) begin
      sat_speed = -`SCSPI_SPD_MAX;
    end else begin
      sat_speed = v;
    end
  endfunction : sat_speed

  function automatic logic signed [15:0] clamp16(input logic signed [15:0] v,
                                                  input logic signed [15:0] lo,
                                                  input logic signed [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp16

  function automatic logic signed [31:0] abs32(input logic signed [31:0] v);
    abs32 = (v < 0) ? -v : v;
  endfunction : abs32

  assign bus = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

  // -----------------------------------------------------------------
  // Submodules
  // -----------------------------------------------------------------
  assign sel_idx = {SPEED_SELECT_BIT2, SPEED_SELECT_BIT1, SPEED_SELECT_BIT0};
  assign tbl_we = bus.wr && (bus.addr[4:3] == `SCSPI_A_TABLE >> 3);

  scspi_speed_mem u_table (
    .clk(SYS_CLK),
    .we(tbl_we),
    .waddr(bus.addr[2:0]),
    .wdata(sat_speed(bus.wdata)),
    .raddr(sel_idx),
    .rdata(table_rd)
  );

  scspi_inh_filter u_inh (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .din(PULSE_INHIBIT_IN),
    .period(s_r.act.inh_per),
    .dout(inh_state)
  );

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  logic signed [31:0] ain;
  logic signed [31:0] err;
  logic signed [31:0] scaled;
  logic signed [31:0] src_cmd;
  logic zc_on;
  logic tick_now;
  always_comb begin
    s_nxt = s_r;
    ain = 32'sh0;
    err = 32'sh0;
    scaled = 32'sh0;
    src_cmd = 32'sh0;
    zc_on = 1'b0;
    tick_now = (s_r.tick == 12'(`SCSPI_TICK_CYC - 1));
    s_nxt.tick = tick_now ? 12'h000 : s_r.tick + 12'h001;

    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        `SCSPI_A_INH_EN: s_nxt.cfg.inh_en = bus.wdata[0];
        `SCSPI_A_INH_PER: s_nxt.cfg.inh_per = (bus.wdata[2:0] > `SCSPI_PER_MAX) ?
                                              `SCSPI_PER_MAX : bus.wdata[2:0];
        `SCSPI_A_SRC: s_nxt.cfg.src = bus.wdata[1:0];
        `SCSPI_A_DIR: s_nxt.cfg.dir = bus.wdata[0];
        `SCSPI_A_GAIN: s_nxt.cfg.gain = clamp16(bus.wdata[15:0], `SCSPI_GAIN_MIN,
                                                `SCSPI_GAIN_MAX);
        `SCSPI_A_POL: s_nxt.cfg.pol = bus.wdata[0];
        `SCSPI_A_OFS: s_nxt.cfg.ofs = clamp16(bus.wdata[15:0], -`SCSPI_OFS_MAX,
                                              `SCSPI_OFS_MAX);
        `SCSPI_A_FILT: s_nxt.cfg.filt = (bus.wdata[15:0] > `SCSPI_FILT_MAX) ?
                                        `SCSPI_FILT_MAX : bus.wdata[15:0];
        `SCSPI_A_ZC_FUNC: s_nxt.cfg.zc_func = bus.wdata[1:0];
        `SCSPI_A_ZC_LVL: s_nxt.cfg.zc_lvl = bus.wdata[15:0];
        `SCSPI_A_PCOUNT: s_nxt.pcount = bus.wdata;
        default: begin
        end
      endcase
    end

    // Read data, one cycle later
    s_nxt.rdata = 32'h0;
    if (bus.rd) begin
      case (bus.addr)
        `SCSPI_A_INH_EN: s_nxt.rdata = {31'h0, s_r.cfg.inh_en};
        `SCSPI_A_INH_PER: s_nxt.rdata = {29'h0, s_r.cfg.inh_per};
        `SCSPI_A_SRC: s_nxt.rdata = {30'h0, s_r.cfg.src};
        `SCSPI_A_DIR: s_nxt.rdata = {31'h0, s_r.cfg.dir};
        `SCSPI_A_GAIN: s_nxt.rdata = 32'(s_r.cfg.gain);
        `SCSPI_A_POL: s_nxt.rdata = {31'h0, s_r.cfg.pol};
        `SCSPI_A_OFS: s_nxt.rdata = 32'(s_r.cfg.ofs);
        `SCSPI_A_FILT: s_nxt.rdata = {16'h0, s_r.cfg.filt};
        `SCSPI_A_ZC_FUNC: s_nxt.rdata = {30'h0, s_r.cfg.zc_func};
        `SCSPI_A_ZC_LVL: s_nxt.rdata = {16'h0, s_r.cfg.zc_lvl};
        `SCSPI_A_PCOUNT: s_nxt.rdata = s_r.pcount;
        `SCSPI_A_SPEED: s_nxt.rdata = s_r.speed;
        `SCSPI_A_STATUS: s_nxt.rdata = {30'h0, s_r.hold, inh_state};
        default: s_nxt.rdata = 32'h0;
      endcase
    end

    // Pulse counting, gated by filtered inhibit
    if (CMD_PULSE && !(s_r.act.inh_en && inh_state)) begin
      s_nxt.pcount = CMD_DIR ? s_r.pcount - 32'h1 : s_r.pcount + 32'h1;
    end

    // Control tick: settings copied in, analog path and command updated
    if (tick_now) begin
      s_nxt.act = s_r.cfg;
      ain = 32'(ANALOG_INPUT_ONE) + 32'(s_r.act.ofs);
      err = ain - s_r.filt;
      // Lag: y += (x - y) / (tau + 1), tau in ticks
      // Signed divisor, else a falling input divides as unsigned and runs away
      s_nxt.filt = s_r.filt + 32'(err / ($signed(32'(s_r.act.filt)) + 32'sh1));
      // Full scale 32767 is taken as 10 V
      scaled = 32'((64'(s_r.filt) * 64'(s_r.act.gain) * 64'sh0a) / 64'sh7fff);
      if (s_r.act.pol) begin
        scaled = -scaled;
      end
      if (s_r.act.src == 2'h0) begin
        src_cmd = scaled;
      end else begin
        src_cmd = table_rd;
      end
      if (s_r.act.dir) begin
        src_cmd = DIR_SIGN_IN ? -abs32(src_cmd) : abs32(src_cmd);
      end
      src_cmd = sat_speed(src_cmd);
      // Function 0 ignores the input; others clamp, 2/3 also hold position when the command is within zc_lvl
      zc_on = ZERO_CLAMP_IN && (s_r.act.zc_func != 2'h0);
      s_nxt.hold = 1'b0;
      if (zc_on) begin
        if (s_r.act.zc_func[1] && abs32(src_cmd) <= 32'(s_r.act.zc_lvl)) begin
          s_nxt.hold = 1'b1;
        end
        src_cmd = 32'sh0;
      end
      s_nxt.speed = src_cmd;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      s_r <= '0;
      s_r.cfg.gain <= `SCSPI_GAIN_RST;
      s_r.act.gain <= `SCSPI_GAIN_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign REG_RDATA = s_r.rdata;
  assign SPEED_CMD = s_r.speed;
  assign PULSE_COUNT = s_r.pcount;
  assign POSITION_HOLD = s_r.hold;

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  property p_inhibit_holds;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (s_r.act.inh_en && inh_state && !(bus.wr && bus.addr == `SCSPI_A_PCOUNT))
      |=> $stable(PULSE_COUNT);
  endproperty
  a_inhibit_holds: assert property (p_inhibit_holds) else $error("count moved");
  property p_count_moves;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (CMD_PULSE && !s_r.act.inh_en && !CMD_DIR && !bus.wr)
      |=> PULSE_COUNT == $past(PULSE_COUNT) + 32'h1;
  endproperty
  a_count_moves: assert property (p_count_moves) else $error("pulse lost");
  property p_reset_disabled;
    @(posedge SYS_CLK) $fell(SYS_RST) |-> !s_r.cfg.inh_en;
  endproperty
  a_reset_disabled: assert property (p_reset_disabled) else $error("inh on");
  property p_speed_range;
    @(posedge SYS_CLK) disable iff (SYS_RST) abs32(SPEED_CMD) <= `SCSPI_SPD_MAX;
  endproperty
  a_speed_range: assert property (p_speed_range) else $error("speed out");
  property p_clamp_zero;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (tick_now && ZERO_CLAMP_IN && s_r.act.zc_func != 2'h0) |=> SPEED_CMD == 0;
  endproperty
  a_clamp_zero: assert property (p_clamp_zero) else $error("no clamp");
  property p_hold_mode;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (tick_now && !s_r.act.zc_func[1]) |=> !POSITION_HOLD;
  endproperty
  a_hold_mode: assert property (p_hold_mode) else $error("bad hold");
  property p_gain_range;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      s_r.cfg.gain >= `SCSPI_GAIN_MIN && s_r.cfg.gain <= `SCSPI_GAIN_MAX;
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("gain out");
  property p_speed_tick;
    @(posedge SYS_CLK) disable iff (SYS_RST) !tick_now |=> $stable(SPEED_CMD);
  endproperty
  a_speed_tick: assert property (p_speed_tick) else $error("off tick");
  c_inhibit: cover property (@(posedge SYS_CLK) CMD_PULSE && s_r.act.inh_en && inh_state);
  c_internal: cover property (@(posedge SYS_CLK) tick_now && s_r.act.src != 2'h0);
  c_hold: cover property (@(posedge SYS_CLK) POSITION_HOLD);
endmodule : scspi_top

//--- scspi_consts.svh
// Constants for the speed command select and pulse inhibit block.
// Assumes inclusion by bare name from the design modules and the testbench.
`ifndef SCSPI_CONSTS_SVH
`define SCSPI_CONSTS_SVH
// -----------------------------------------------------------------
// Register indices (byte address = index * 4 is not used; plain port)
// -----------------------------------------------------------------
`define SCSPI_A_INH_EN 5'h00
`define SCSPI_A_INH_PER 5'h01
`define SCSPI_A_SRC 5'h02
`define SCSPI_A_DIR 5'h03
`define SCSPI_A_GAIN 5'h04
`define SCSPI_A_POL 5'h05
`define SCSPI_A_OFS 5'h06
`define SCSPI_A_FILT 5'h07
`define SCSPI_A_ZC_FUNC 5'h08
`define SCSPI_A_ZC_LVL 5'h09
`define SCSPI_A_PCOUNT 5'h0a
`define SCSPI_A_SPEED 5'h0b
`define SCSPI_A_STATUS 5'h0c
`define SCSPI_A_TABLE 5'h10
// -----------------------------------------------------------------
// Limits and reset values
// -----------------------------------------------------------------
`define SCSPI_GAIN_MIN 16'sh000a
`define SCSPI_GAIN_MAX 16'sh07d0
`define SCSPI_GAIN_RST 16'sh01f4
`define SCSPI_OFS_MAX 16'sh15ca
`define SCSPI_FILT_MAX 16'sh1900
`define SCSPI_SPD_MAX 32'sh00004e20
`define SCSPI_PER_MAX 3'h4
// One filter unit is 0.01 ms = 10000 ns; one control tick each unit
`define SCSPI_FILT_UNIT_NS 10000
`define SCSPI_CLK_NS 8
`define SCSPI_TICK_CYC (`SCSPI_FILT_UNIT_NS / `SCSPI_CLK_NS)
// Inhibit filter: samples that must agree
`define SCSPI_INH_AGREE 3'h3
`endif

//--- scspi_pkg.sv
// Types for the speed command select and pulse inhibit block.
// Assumes scspi_consts.svh is reachable by bare name.
package scspi_pkg;
  typedef struct packed {
    logic [4:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } scspi_bus_t;
  typedef struct packed {
    logic inh_en;
    logic [2:0] inh_per;
    logic [1:0] src;
    logic dir;
    logic signed [15:0] gain;
    logic pol;
    logic signed [15:0] ofs;
    logic [15:0] filt;
    logic [1:0] zc_func;
    logic [15:0] zc_lvl;
  } scspi_cfg_t;
endpackage : scspi_pkg

//--- scspi_speed_mem.sv
// Eight-word table of stored internal speeds, registered read.
// Assumes one clock; the table has no reset.
`timescale 1ns/1ps
module scspi_speed_mem (
  input wire logic clk,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic signed [31:0] wdata,
  input wire logic [2:0] raddr,
  output logic signed [31:0] rdata
);
  logic signed [31:0] mem [0:7];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : scspi_speed_mem

//--- scspi_inh_filter.sv
// Inhibit input filter: state moves only after agreeing samples.
// Assumes the input is synchronous to the clock.
`timescale 1ns/1ps
`include "scspi_consts.svh"
module scspi_inh_filter (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  input wire logic [2:0] period,
  output logic dout
);
  typedef struct packed {
    logic [7:0] div;
    logic [2:0] agree;
    logic last;
    logic out;
  } scspi_inhf_t;
  scspi_inhf_t s_r, s_nxt;
  logic sample;
  // Period p samples every 2**p cycles; p=0 samples every cycle
  assign sample = ((s_r.div & ((8'h01 << period) - 8'h01)) == 8'h00);
  always_comb begin
    s_nxt = s_r;
    s_nxt.div = s_r.div + 8'h01;
    if (sample) begin
      s_nxt.last = din;
      if (din != s_r.last) begin
        s_nxt.agree = 3'h1;
      end else if (s_r.agree < `SCSPI_INH_AGREE) begin
        s_nxt.agree = s_r.agree + 3'h1;
      end
      if (din == s_r.last && s_r.agree + 3'h1 >= `SCSPI_INH_AGREE) begin
        s_nxt.out = din;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign dout = s_r.out;
endmodule : scspi_inh_filter

//--- scspi_host_model.sv
// Host controller model: command pulses, contact inputs, analog voltage.
// Assumes one clock; every line changes just after a rising edge.
`timescale 1ns/1ps
module scspi_host_model (
  input wire logic clk,
  output logic pulse,
  output logic pulse_dir,
  output logic inhibit,
  output logic [2:0] sel,
  output logic clamp,
  output logic sign,
  output logic signed [15:0] analog
);
  initial begin
    pulse = 1'b0;
    pulse_dir = 1'b0;
    inhibit = 1'b0;
    sel = 3'h0;
    clamp = 1'b0;
    sign = 1'b0;
    analog = 16'sh0000;
  end
  // Gap 0 holds the line high n cycles; otherwise one idle cycle each
  task automatic send_pulses(input int n, input logic d, input int gap);
    if (gap == 0) begin
      @(posedge clk);
      pulse <= 1'b1;
      pulse_dir <= d;
      repeat (n) @(posedge clk);
      pulse <= 1'b0;
    end else begin
      for (int i = 0; i < n; i++) begin
        @(posedge clk);
        pulse <= 1'b1;
        pulse_dir <= d;
        @(posedge clk);
        pulse <= 1'b0;
      end
    end
  endtask : send_pulses
  task automatic drive(input logic i, input logic [2:0] s, input logic c, input logic g,
                       input logic signed [15:0] a);
    @(posedge clk);
    inhibit <= i;
    sel <= s;
    clamp <= c;
    sign <= g;
    analog <= a;
  endtask : drive
endmodule : scspi_host_model

//--- tb_speed_command_select_and_pulse_inhibit.sv
// Self-checking bench for the speed command select and pulse inhibit block.
// Assumes the design files and scspi_host_model are compiled first.
`timescale 1ns/1ps
`include "scspi_consts.svh"
module tb_speed_command_select_and_pulse_inhibit;
  import scspi_pkg::*;
  localparam int TICK = 1250;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic pulse;
  logic pdir;
  logic inh;
  logic [2:0] sel;
  logic clamp;
  logic sign;
  logic signed [15:0] ana;
  logic signed [31:0] speed;
  logic [31:0] pcount;
  logic hold;
  logic [31:0] v;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  scspi_top i_dut (.SYS_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .CMD_PULSE(pulse), .CMD_DIR(pdir),
    .PULSE_INHIBIT_IN(inh), .SPEED_SELECT_BIT0(sel[0]), .SPEED_SELECT_BIT1(sel[1]),
    .SPEED_SELECT_BIT2(sel[2]), .ZERO_CLAMP_IN(clamp), .DIR_SIGN_IN(sign),
    .ANALOG_INPUT_ONE(ana), .SPEED_CMD(speed), .PULSE_COUNT(pcount), .POSITION_HOLD(hold));
  scspi_host_model i_host (.clk(clk), .pulse(pulse), .pulse_dir(pdir), .inhibit(inh),
    .sel(sel), .clamp(clamp), .sign(sign), .analog(ana));
  // ---------------------------------------------------------------
  // Bus and compare helpers
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  // Data stands only in the cycle after the strobe
  task automatic rd_chk(input string name, input logic [4:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(name, e, rdata);
  endtask : rd_chk
  task automatic settle();
    repeat (2 * TICK + 20) @(posedge clk);
  endtask : settle
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_and_limits();
    logic [4:0] la[4] = '{`SCSPI_A_GAIN, `SCSPI_A_GAIN, `SCSPI_A_OFS, `SCSPI_A_INH_PER};
    logic [31:0] lw[4] = '{32'h5, 32'hbb8, 32'h1770, 32'h7};
    logic [31:0] le[4] = '{32'ha, 32'h7d0, 32'h15ca, 32'h4};
    rd_chk("inh_en", `SCSPI_A_INH_EN, 32'h0);
    rd_chk("gain", `SCSPI_A_GAIN, 32'h1f4);
    rd_chk("source", `SCSPI_A_SRC, 32'h0);
    rd_chk("unmapped", 5'h1f, 32'h0);
    chk("count", 32'h0, pcount);
    for (int i = 0; i < 4; i++) begin
      reg_wr(la[i], lw[i]);
      rd_chk("limit", la[i], le[i]);
    end
    reg_wr(`SCSPI_A_GAIN, 32'h1f4);
    reg_wr(`SCSPI_A_OFS, 32'h0);
    reg_wr(`SCSPI_A_INH_PER, 32'h0);
  endtask : t_reset_and_limits
  task automatic t_inhibit();
    i_host.drive(1'b1, 3'h0, 1'b0, 1'b0, 16'sh0);
    i_host.send_pulses(5, 1'b0, 0);
    repeat (2) @(posedge clk);
    chk("count_off", 32'h5, pcount);
    reg_wr(`SCSPI_A_INH_EN, 32'h1);
    settle();
    rd_chk("status", `SCSPI_A_STATUS, 32'h1);
    i_host.send_pulses(4, 1'b0, 1);
    repeat (2) @(posedge clk);
    chk("count_inh", 32'h5, pcount);
    i_host.drive(1'b0, 3'h0, 1'b0, 1'b0, 16'sh0);
    repeat (80) @(posedge clk);
    rd_chk("status_clr", `SCSPI_A_STATUS, 32'h0);
    i_host.send_pulses(2, 1'b1, 1);
    repeat (2) @(posedge clk);
    chk("count_down", 32'h3, pcount);
    reg_wr(`SCSPI_A_INH_PER, 32'h4);
    settle();
    i_host.drive(1'b1, 3'h0, 1'b0, 1'b0, 16'sh0);
    repeat (8) @(posedge clk);
    rd_chk("slow_early", `SCSPI_A_STATUS, 32'h0);
    repeat (80) @(posedge clk);
    rd_chk("slow_late", `SCSPI_A_STATUS, 32'h1);
  endtask : t_inhibit
  task automatic t_table();
    logic [31:0] w[8] = '{32'hffffb1e0, 32'h101, 32'h102, 32'h103, 32'h104, 32'h105,
      32'h106, 32'h7530};
    reg_wr(`SCSPI_A_SRC, 32'h1);
    for (int i = 0; i < 8; i++) reg_wr(`SCSPI_A_TABLE + 5'(i), w[i]);
    for (int i = 0; i < 8; i++) begin
      i_host.drive(1'b0, 3'(i), 1'b0, 1'b0, 16'sh0);
      settle();
      chk("table", (i == 7) ? 32'h4e20 : w[i], speed);
    end
  endtask : t_table
  task automatic t_clamp();
    i_host.drive(1'b0, 3'h1, 1'b1, 1'b0, 16'sh0);
    settle();
    chk("clamp_off", 32'h101, speed);
    reg_wr(`SCSPI_A_ZC_FUNC, 32'h1);
    settle();
    chk("clamp_on", 32'h0, speed);
    reg_wr(`SCSPI_A_ZC_LVL, 32'h10);
    reg_wr(`SCSPI_A_ZC_FUNC, 32'h2);
    settle();
    chk("hold_far", 32'h0, {31'h0, hold});
    reg_wr(`SCSPI_A_ZC_LVL, 32'h200);
    settle();
    chk("hold", 32'h1, {31'h0, hold});
    reg_wr(`SCSPI_A_ZC_FUNC, 32'h0);
    i_host.drive(1'b0, 3'h0, 1'b0, 1'b0, 16'sh0);
  endtask : t_clamp
  task automatic t_analog();
    logic [2:0] c[4] = '{3'b000, 3'b100, 3'b011, 3'b010};
    logic n[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    reg_wr(`SCSPI_A_SRC, 32'h0);
    settle();
    chk("ana_zero", 32'h0, speed);
    reg_wr(`SCSPI_A_OFS, 32'h3e8);
    // Offset, filter and scaling each take one tick
    settle();
    repeat (TICK) @(posedge clk);
    chk("ofs_pos", 32'h0, {31'h0, speed[31] | (speed == 0)});
    reg_wr(`SCSPI_A_OFS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      reg_wr(`SCSPI_A_POL, {31'h0, c[i][2]});
      reg_wr(`SCSPI_A_DIR, {31'h0, c[i][1]});
      i_host.drive(1'b0, 3'h0, 1'b0, c[i][0], 16'sh3e80);
      settle();
      chk("sign", {31'h0, n[i]}, {31'h0, speed[31]});
      chk("nonzero", 32'h1, {31'h0, speed != 0});
    end
    reg_wr(`SCSPI_A_FILT, 32'h2000);
    rd_chk("filt", `SCSPI_A_FILT, 32'h1900);
    settle();
    i_host.drive(1'b0, 3'h0, 1'b0, 1'b0, 16'sh0);
    settle();
    // Slowest lag: a step to zero barely moves the command in two ticks
    chk("lag", 32'h1, {31'h0, speed > 32'sd2400 && speed < 32'sd2442});
  endtask : t_analog
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  // Hang guard well above the expected run of about 57000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      $display("Error timeout expected done seen running");
      finish_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset_and_limits();
    t_inhibit();
    t_table();
    t_clamp();
    t_analog();
    finish_test();
  end
endmodule : tb_speed_command_select_and_pulse_inhibit
